// *** src/supervisor_consts.svh ***
`ifndef SUPERVISOR_CONSTS_SVH
`define SUPERVISOR_CONSTS_SVH

// Register map
`define ADDR_STATUS 8'h20
`define ADDR_RST_CFG 8'h3b
`define ADDR_RST_TRIG 8'h3c
`define ADDR_RST_SRC_HI 8'h3d
`define ADDR_DOG_CFG 8'h76

// Field positions
`define STAT_RST_BIT 0
`define STAT_DOGRST_BIT 1
`define CFG_CLASS_MSB 1
`define CFG_POL_BIT 2
`define CFG_PUSHPULL_BIT 3
`define CFG_TRP_MSB 7
`define CFG_TRP_LSB 4
`define TRIG_SOFT_BIT 0
`define SRC_HI_USED_MSB 4
`define DOG_RSTEN_BIT 7
`define DOG_START_MSB 6
`define DOG_START_LSB 4
`define DOG_TO_MSB 3

// Reset values
`define RST_CFG_INIT 8'h00
`define RST_TRIG_INIT 8'h00
`define RST_SRC_HI_INIT 8'h00
`define DOG_CFG_INIT 8'h00

// Threshold class codes
`define CLASS_UV 2'h0
`define CLASS_EW 2'h1
`define CLASS_OV 2'h2

// Timing
`define MCLK_PERIOD_NS 32'h0000_0032
`define TICK_NS 32'h0000_03e8

// Reset pulse periods in microseconds
`define TRP_0 32'h0000_0019
`define TRP_1 32'h0000_05dc
`define TRP_2 32'h0000_09c4
`define TRP_3 32'h0000_0fa0
`define TRP_4 32'h0000_1770
`define TRP_5 32'h0000_2710
`define TRP_6 32'h0000_3a98
`define TRP_7 32'h0000_61a8
`define TRP_8 32'h0000_9c40
`define TRP_9 32'h0000_ea60
`define TRP_A 32'h0001_86a0
`define TRP_B 32'h0002_49f0
`define TRP_C 32'h0003_d090
`define TRP_D 32'h0006_1a80
`define TRP_E 32'h0009_27c0
`define TRP_F 32'h000f_4240

// Kick timeout periods in microseconds
`define KTO_1 32'h0000_03e8
`define KTO_2 32'h0000_07d0
`define KTO_3 32'h0000_0fa0
`define KTO_4 32'h0000_1f40
`define KTO_5 32'h0000_36b0
`define KTO_6 32'h0000_6978
`define KTO_7 32'h0000_c350
`define KTO_8 32'h0001_86a0
`define KTO_9 32'h0003_0d40
`define KTO_A 32'h0006_1a80
`define KTO_B 32'h000b_71b0
`define KTO_C 32'h0015_5cc0
`define KTO_D 32'h0029_32e0
`define KTO_E 32'h004c_4b40
`define KTO_F 32'h0098_9680

// Startup kick periods in microseconds
`define SKP_1 32'h01c9_c380
`define SKP_2 32'h0262_5a00
`define SKP_3 32'h04c4_b400
`define SKP_4 32'h0727_0e00
`define SKP_5 32'h0989_6800
`define SKP_6 32'h0d1c_ef00
`define SKP_7 32'h11e1_a300

`endif

// *** src/supervisor_pkg.sv ***
`default_nettype none
package supervisor_pkg;

  typedef enum logic [2:0] {
    RST_HOLD = 3'h1,
    RST_PULSE = 3'h2,
    RST_IDLE = 3'h4
  } rst_state_t;

  typedef enum logic [3:0] {
    DOG_OFF = 4'h1,
    DOG_STARTUP = 4'h2,
    DOG_NORMAL = 4'h4,
    DOG_EXPIRED = 4'h8
  } dog_state_t;

endpackage
`default_nettype wire

// *** src/sync2.sv ***
`default_nettype none
module sync2 (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Asynchronous level in, synchronised level out
  input wire logic async_in,
  output logic sync_out
);

  logic meta_r;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      meta_r <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule
`default_nettype wire

// *** src/period_timer.sv ***
`default_nettype none
module period_timer (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // One-microsecond enable
  input wire logic tick,
  // Load a fresh period, in ticks
  input wire logic load,
  input wire logic [31:0] load_val,
  // High once the period has run out
  output logic done
);

  logic [31:0] cnt_r;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cnt_r <= 32'h0000_0000;
    end else if (load) begin
      cnt_r <= load_val;
    end else if (tick && (cnt_r != 32'h0000_0000)) begin
      cnt_r <= cnt_r - 32'h0000_0001;
    end
  end

  assign done = (cnt_r == 32'h0000_0000) && !load;

endmodule
`default_nettype wire

// *** src/reset_output_and_watchdog.sv ***
`include "supervisor_consts.svh"
`default_nettype none
module reset_output_and_watchdog #(
  // Right shift applied to every period, so simulation can shorten them
  parameter int unsigned TIME_SHIFT = 0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  output logic [7:0] reg_rdata,
  // Pins from outside
  input wire logic enable_pin,
  input wire logic kick_input,
  // Sequencer and threshold comparators
  input wire logic power_on_done,
  input wire logic [11:0] uv_fault,
  input wire logic [11:0] ew_fault,
  input wire logic [11:0] ov_fault,
  input wire logic [11:0] crit_fault,
  // Reset pin, drive level and enable
  output logic reset_pin_out,
  output logic reset_pin_oe,
  // Watchdog expiry pin, active low
  output logic dog_expiry_output_n,
  // Internal reset state, high while asserted
  output logic reset_asserted
);
  import supervisor_pkg::*;

  localparam logic [31:0] TICK_CYCLES =
    (`TICK_NS + `MCLK_PERIOD_NS - 32'h0000_0001) / `MCLK_PERIOD_NS;

  // Configuration registers
  logic [7:0] rst_cfg_r;
  logic [7:0] rst_trig_r;
  logic [7:0] rst_src_hi_r;
  logic [7:0] dog_cfg_r;
  logic dog_caused_reset_flag_r;

  // Write strobes per register
  logic wr_cfg;
  logic wr_trig;
  logic wr_src_hi;
  logic wr_dog;
  logic wr_stat;

  assign wr_cfg = reg_wr && (reg_addr == `ADDR_RST_CFG);
  assign wr_trig = reg_wr && (reg_addr == `ADDR_RST_TRIG);
  assign wr_src_hi = reg_wr && (reg_addr == `ADDR_RST_SRC_HI);
  assign wr_dog = reg_wr && (reg_addr == `ADDR_DOG_CFG);
  assign wr_stat = reg_wr && (reg_addr == `ADDR_STATUS);

  // Period tables
  function automatic logic [31:0] scale(input logic [31:0] us);
    logic [31:0] v;
    v = us >> TIME_SHIFT;
    // Never shorter than one tick
    if (v == 32'h0000_0000) begin
      v = 32'h0000_0001;
    end
    return v;
  endfunction

  function automatic logic [31:0] trp_us(input logic [3:0] code);
    logic [31:0] v;
    case (code)
      4'h0: v = `TRP_0;
      4'h1: v = `TRP_1;
      4'h2: v = `TRP_2;
      4'h3: v = `TRP_3;
      4'h4: v = `TRP_4;
      4'h5: v = `TRP_5;
      4'h6: v = `TRP_6;
      4'h7: v = `TRP_7;
      4'h8: v = `TRP_8;
      4'h9: v = `TRP_9;
      4'ha: v = `TRP_A;
      4'hb: v = `TRP_B;
      4'hc: v = `TRP_C;
      4'hd: v = `TRP_D;
      4'he: v = `TRP_E;
      default: v = `TRP_F;
    endcase
    return v;
  endfunction

  function automatic logic [31:0] kto_us(input logic [3:0] code);
    logic [31:0] v;
    case (code)
      4'h1: v = `KTO_1;
      4'h2: v = `KTO_2;
      4'h3: v = `KTO_3;
      4'h4: v = `KTO_4;
      4'h5: v = `KTO_5;
      4'h6: v = `KTO_6;
      4'h7: v = `KTO_7;
      4'h8: v = `KTO_8;
      4'h9: v = `KTO_9;
      4'ha: v = `KTO_A;
      4'hb: v = `KTO_B;
      4'hc: v = `KTO_C;
      4'hd: v = `KTO_D;
      4'he: v = `KTO_E;
      default: v = `KTO_F;
    endcase
    return v;
  endfunction

  function automatic logic [31:0] skp_us(input logic [2:0] code);
    logic [31:0] v;
    case (code)
      3'h1: v = `SKP_1;
      3'h2: v = `SKP_2;
      3'h3: v = `SKP_3;
      3'h4: v = `SKP_4;
      3'h5: v = `SKP_5;
      3'h6: v = `SKP_6;
      default: v = `SKP_7;
    endcase
    return v;
  endfunction

  // Register writes
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rst_cfg_r <= `RST_CFG_INIT;
      rst_trig_r <= `RST_TRIG_INIT;
      rst_src_hi_r <= `RST_SRC_HI_INIT;
      dog_cfg_r <= `DOG_CFG_INIT;
    end else begin
      if (wr_cfg) begin
        rst_cfg_r <= reg_wdata;
      end
      if (wr_trig) begin
        rst_trig_r <= reg_wdata;
      end
      if (wr_src_hi) begin
        rst_src_hi_r <= reg_wdata;
      end
      if (wr_dog) begin
        dog_cfg_r <= reg_wdata;
      end
    end
  end

  // Read data, one cycle after the address
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        `ADDR_STATUS: begin
          reg_rdata <= 8'h00;
          reg_rdata[`STAT_RST_BIT] <= reset_asserted;
          reg_rdata[`STAT_DOGRST_BIT] <= dog_caused_reset_flag_r;
        end
        `ADDR_RST_CFG: reg_rdata <= rst_cfg_r;
        `ADDR_RST_TRIG: reg_rdata <= rst_trig_r;
        `ADDR_RST_SRC_HI: reg_rdata <= {3'h0, rst_src_hi_r[`SRC_HI_USED_MSB:0]};
        `ADDR_DOG_CFG: reg_rdata <= dog_cfg_r;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // Microsecond tick
  logic [31:0] tick_cnt_r;
  logic tick;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tick_cnt_r <= 32'h0000_0000;
    end else if (tick) begin
      tick_cnt_r <= 32'h0000_0000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
    end
  end

  assign tick = (tick_cnt_r == TICK_CYCLES - 32'h0000_0001);

  // Pin synchronisers
  logic enable_s;
  logic kick_s;
  logic kick_d_r;
  logic kick_edge;

  sync2 u_sync_enable (
    .mclk(mclk),
    .reset(reset),
    .async_in(enable_pin),
    .sync_out(enable_s)
  );

  sync2 u_sync_kick (
    .mclk(mclk),
    .reset(reset),
    .async_in(kick_input),
    .sync_out(kick_s)
  );

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      kick_d_r <= 1'b0;
    end else begin
      kick_d_r <= kick_s;
    end
  end

  assign kick_edge = kick_s ^ kick_d_r;

  // Monitored channel faults
  logic [11:0] chan_sel;
  logic [11:0] class_fault;
  logic mon_fault;

  assign chan_sel = {rst_src_hi_r[`SRC_HI_USED_MSB:0], rst_trig_r[7:1]};

  always_comb begin
    case (rst_cfg_r[`CFG_CLASS_MSB:0])
      `CLASS_UV: class_fault = uv_fault;
      `CLASS_EW: class_fault = ew_fault;
      `CLASS_OV: class_fault = ov_fault;
      default: class_fault = uv_fault | ov_fault;
    endcase
  end

  assign mon_fault = |(class_fault & chan_sel) || |crit_fault;

  // Reset output state machine
  rst_state_t rst_state_r;
  rst_state_t rst_state_nxt;
  logic rst_src;
  logic rst_load;
  logic rst_done;
  logic dog_trip;

  assign rst_src = !power_on_done || rst_trig_r[`TRIG_SOFT_BIT] || mon_fault
    || dog_trip;

  always_comb begin
    rst_state_nxt = rst_state_r;
    rst_load = 1'b0;
    case (rst_state_r)
      RST_HOLD: begin
        if (!rst_src) begin
          rst_state_nxt = RST_PULSE;
          rst_load = 1'b1;
        end
      end
      RST_PULSE: begin
        if (rst_src) begin
          rst_state_nxt = RST_HOLD;
        end else if (wr_cfg) begin
          rst_load = 1'b1;
        end else if (rst_done) begin
          rst_state_nxt = RST_IDLE;
        end
      end
      RST_IDLE: begin
        if (rst_src) begin
          rst_state_nxt = RST_HOLD;
        end
      end
      default: rst_state_nxt = RST_HOLD;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rst_state_r <= RST_HOLD;
    end else begin
      rst_state_r <= rst_state_nxt;
    end
  end

  period_timer u_trp_timer (
    .mclk(mclk),
    .reset(reset),
    .tick(tick),
    .load(rst_load),
    .load_val(scale(trp_us(rst_cfg_r[`CFG_TRP_MSB:`CFG_TRP_LSB]))),
    .done(rst_done)
  );

  assign reset_asserted = (rst_state_r != RST_IDLE);

  // Pin drive: polarity and open drain or push-pull
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      reset_pin_out <= 1'b0;
      reset_pin_oe <= 1'b1;
    end else if (rst_cfg_r[`CFG_PUSHPULL_BIT]) begin
      reset_pin_out <= reset_asserted ~^ rst_cfg_r[`CFG_POL_BIT];
      reset_pin_oe <= 1'b1;
    end else begin
      // Open drain only pulls low; the high level comes from the pull-up
      reset_pin_out <= 1'b0;
      reset_pin_oe <= !(reset_asserted ~^ rst_cfg_r[`CFG_POL_BIT]);
    end
  end

  // Watchdog state machine
  dog_state_t dog_state_r;
  dog_state_t dog_state_nxt;
  logic dog_ok;
  logic dog_load;
  logic [31:0] dog_val;
  logic dog_done;
  logic [31:0] kto_ticks;
  logic [31:0] skp_ticks;

  assign kto_ticks = scale(kto_us(dog_cfg_r[`DOG_TO_MSB:0]));
  assign skp_ticks = scale(skp_us(dog_cfg_r[`DOG_START_MSB:`DOG_START_LSB]));

  assign dog_ok = enable_s && power_on_done && !reset_asserted
    && (dog_cfg_r[`DOG_TO_MSB:0] != 4'h0);

  always_comb begin
    dog_state_nxt = dog_state_r;
    dog_load = 1'b0;
    dog_val = kto_ticks;
    if (!dog_ok || wr_dog) begin
      dog_state_nxt = DOG_OFF;
    end else begin
      case (dog_state_r)
        DOG_OFF: begin
          dog_load = 1'b1;
          if (dog_cfg_r[`DOG_START_MSB:`DOG_START_LSB] != 3'h0) begin
            dog_state_nxt = DOG_STARTUP;
            dog_val = skp_ticks;
          end else begin
            dog_state_nxt = DOG_NORMAL;
          end
        end
        DOG_STARTUP: begin
          if (kick_edge) begin
            dog_state_nxt = DOG_NORMAL;
            dog_load = 1'b1;
          end else if (dog_done) begin
            dog_state_nxt = DOG_EXPIRED;
          end
        end
        DOG_NORMAL: begin
          if (kick_edge) begin
            dog_load = 1'b1;
          end else if (dog_done) begin
            dog_state_nxt = DOG_EXPIRED;
          end
        end
        DOG_EXPIRED: begin
          if (kick_edge) begin
            dog_state_nxt = DOG_NORMAL;
            dog_load = 1'b1;
          end
        end
        default: dog_state_nxt = DOG_OFF;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      dog_state_r <= DOG_OFF;
    end else begin
      dog_state_r <= dog_state_nxt;
    end
  end

  period_timer u_dog_timer (
    .mclk(mclk),
    .reset(reset),
    .tick(tick),
    .load(dog_load),
    .load_val(dog_val),
    .done(dog_done)
  );

  // Trip waits for the next tick so the expiry pulse lasts up to 1us
  assign dog_trip = (dog_state_r == DOG_EXPIRED) && dog_cfg_r[`DOG_RSTEN_BIT]
    && tick && !reset_asserted;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      dog_expiry_output_n <= 1'b1;
    end else begin
      dog_expiry_output_n <= (dog_state_r != DOG_EXPIRED);
    end
  end

  // Cause flag; a trip in the clearing cycle wins
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      dog_caused_reset_flag_r <= 1'b0;
    end else if (dog_trip) begin
      dog_caused_reset_flag_r <= 1'b1;
    end else if (wr_stat && reg_wdata[`STAT_DOGRST_BIT]) begin
      dog_caused_reset_flag_r <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// *** tb/reset_output_and_watchdog_assertions.sv ***
`default_nettype none
module reset_output_and_watchdog_checker #(
  parameter int unsigned TIME_SHIFT = 0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [7:0] reg_rdata,
  // Pins and sources
  input wire logic enable_pin,
  input wire logic kick_input,
  input wire logic power_on_done,
  input wire logic [11:0] crit_fault,
  // Outputs watched
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic dog_expiry_output_n,
  input wire logic reset_asserted
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cfg_r;
  logic rsten_r;
  logic [3:0] quiet_r;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // Shadows of the bits the pin and the trip path depend on
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cfg_r <= 8'h00;
      rsten_r <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == 8'h3b) cfg_r <= reg_wdata;
      if (reg_addr == 8'h76) rsten_r <= reg_wdata[7];
    end
  end
  // Quiet time must outlast the kick synchroniser, hence more than four
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) quiet_r <= 4'h0;
    else if ($changed(kick_input) || !enable_pin || reg_wr) quiet_r <= 4'h0;
    else if (quiet_r != 4'hf) quiet_r <= quiet_r + 4'h1;
  end
  sequence soft_trig_write;
    reg_wr && reg_addr == 8'h3c && reg_wdata[0];
  endsequence
  sequence dog_trip;
    $fell(dog_expiry_output_n) && rsten_r;
  endsequence
  chk_soft_trig_asserts: assert property (soft_trig_write |-> ##[1:2] reset_asserted)
    else $error("soft trigger write did not assert reset");
  chk_pin_level: assert property (reset_pin_oe == ($past(cfg_r[3]) |
      ($past(reset_asserted) ^ $past(cfg_r[2]))) && reset_pin_out ==
      ($past(cfg_r[3]) & ($past(reset_asserted) ~^ $past(cfg_r[2]))))
    else $error("reset pin level or enable wrong");
  chk_crit_forces: assert property (crit_fault != 12'h000 |-> ##[1:2] reset_asserted)
    else $error("critical fault did not assert reset");
  chk_power_waits: assert property (!power_on_done |-> ##[1:2] reset_asserted)
    else $error("reset not held before power-on completion");
  chk_enable_holds: assert property (!enable_pin [*5] |-> dog_expiry_output_n)
    else $error("expiry output low while enable low");
  chk_reset_clears: assert property (reset_asserted [*4] |-> dog_expiry_output_n)
    else $error("expiry output low while reset asserted");
  chk_trip_resets: assert property (dog_trip |-> ##[0:24] reset_asserted)
    else $error("expiry with reset enable did not assert reset");
  chk_trip_short: assert property (dog_trip |-> ##[1:25] dog_expiry_output_n)
    else $error("expiry pulse too long with reset enable");
  chk_expiry_holds: assert property (!dog_expiry_output_n && quiet_r > 4'h4 &&
      !reset_asserted |=> !dog_expiry_output_n || reset_asserted)
    else $error("expiry output released without kick or reset");
  chk_kick_clears: assert property (!dog_expiry_output_n && $changed(kick_input)
      |-> ##[2:6] dog_expiry_output_n)
    else $error("kick edge did not release expiry output");
  chk_reserved_zero: assert property (reg_addr == 8'h3d |=> reg_rdata[7:5] == 3'h0)
    else $error("reserved bits read nonzero");
endmodule
bind reset_output_and_watchdog reset_output_and_watchdog_checker #(.TIME_SHIFT(TIME_SHIFT)) u_chk (
  .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rdata(reg_rdata), .enable_pin(enable_pin), .kick_input(kick_input),
  .power_on_done(power_on_done), .crit_fault(crit_fault), .reset_pin_out(reset_pin_out),
  .reset_pin_oe(reset_pin_oe), .dog_expiry_output_n(dog_expiry_output_n),
  .reset_asserted(reset_asserted)
);
`default_nettype wire

// *** tb/kick_host.sv ***
`default_nettype none
module kick_host #(
  parameter logic [7:0] GAP = 8'h27
) (
  // Clock
  input wire logic mclk,
  // Bench control
  input wire logic run,
  // Kick pin
  output logic kick_input
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_r = 8'h00;
  logic lvl_r = 1'b0;
  assign kick_input = lvl_r;
  // A stopped host leaves the pin at its last level, as a stalled processor would
  always @(posedge mclk) begin
    if (!run || cnt_r == GAP) cnt_r <= 8'h00;
    else cnt_r <= cnt_r + 8'h01;
    if (run && cnt_r == GAP) lvl_r <= !lvl_r;
  end
endmodule
`default_nettype wire

// *** tb/reset_output_and_watchdog_tb.sv ***
`include "supervisor_consts.svh"
`default_nettype none
module reset_output_and_watchdog_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SH = 16;
  localparam int TK = 20;
  localparam int KTO = `KTO_A >> SH;
  localparam int TRPF = `TRP_F >> SH;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic enable_pin = 1'b1;
  logic power_on_done = 1'b1;
  logic [11:0] uv_fault = 12'h000;
  logic [11:0] ew_fault = 12'h000;
  logic [11:0] ov_fault = 12'h000;
  logic [11:0] crit_fault = 12'h000;
  logic run = 1'b1;
  logic [7:0] reg_rdata;
  logic kick_input;
  logic reset_pin_out;
  logic reset_pin_oe;
  logic dog_expiry_output_n;
  logic reset_asserted;
  logic [11:0] chans [4] = '{12'h400, 12'h800, 12'h002, 12'h001};
  int fails = 0;
  int samples_checked = 0;

  always #25 mclk = ~mclk;

  reset_output_and_watchdog #(.TIME_SHIFT(SH)) dut (
    .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rdata(reg_rdata), .enable_pin(enable_pin), .kick_input(kick_input),
    .power_on_done(power_on_done), .uv_fault(uv_fault), .ew_fault(ew_fault),
    .ov_fault(ov_fault), .crit_fault(crit_fault), .reset_pin_out(reset_pin_out),
    .reset_pin_oe(reset_pin_oe), .dog_expiry_output_n(dog_expiry_output_n),
    .reset_asserted(reset_asserted)
  );
  kick_host #(.GAP(8'h27)) host (.mclk(mclk), .run(run), .kick_input(kick_input));

  task automatic end_of_test;
    if (fails == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic chk1(input string nm, input logic seen, input logic exp);
    chk(nm, {7'h00, seen}, {7'h00, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    @(posedge mclk);
    #1 chk("reg_rdata", reg_rdata & m, exp);
  endtask
  task automatic skip(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Bounded wait; the caller's check reports a miss
  task automatic wait_on(input bit dog, input logic lvl, input int n);
    repeat (n) begin
      if ((dog ? dog_expiry_output_n : reset_asserted) === lvl) break;
      skip(1);
    end
  endtask
  // Stop right after a toggle so the quiet time is known
  task automatic stop_kicks;
    @(kick_input);
    run <= 1'b0;
  endtask

  initial begin
    #(20000 * 50);
    fails++;
    end_of_test();
  end

  initial begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    wait_on(1'b0, 1'b0, 100);
    chk1("rst_release", reset_asserted, 1'b0);
    rd(8'h3b, 8'hff, 8'h00);
    rd(8'h3c, 8'hff, 8'h00);
    rd(8'h76, 8'hff, 8'h00);
    rd(8'h55, 8'hff, 8'h00);
    wr(8'h3d, 8'hff);
    rd(8'h3d, 8'hff, 8'h1f);
    wr(8'h3d, 8'h00);
    wr(8'h3c, 8'h02);
    for (int c = 0; c < 4; c++) begin
      wr(8'h3b, 8'h0c | 8'(c));
      for (int k = 0; k < 3; k++) begin
        @(posedge mclk);
        uv_fault <= {11'h000, k == 0};
        ew_fault <= {11'h000, k == 1};
        ov_fault <= {11'h000, k == 2};
        skip(4);
        chk1("class", reset_asserted, c == k || (c == 3 && k != 1));
        @(posedge mclk) {uv_fault, ew_fault, ov_fault} <= 36'h0_0000_0000;
        wait_on(1'b0, 1'b0, 80);
      end
    end
    wr(8'h3b, 8'h0b);
    wr(8'h3d, 8'h10);
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk) uv_fault <= chans[k];
      skip(4);
      chk1("channel", reset_asserted, k[0]);
      chk1("pin", reset_pin_out, !k[0]);
      @(posedge mclk) uv_fault <= 12'h000;
      wait_on(1'b0, 1'b0, 80);
    end
    @(posedge mclk) crit_fault <= 12'h020;
    skip(4);
    chk1("crit", reset_asserted, 1'b1);
    @(posedge mclk) crit_fault <= 12'h000;
    wait_on(1'b0, 1'b0, 80);
    wr(8'h3b, 8'hf0);
    wr(8'h3c, 8'h03);
    skip(4);
    chk1("trig", reset_asserted, 1'b1);
    chk1("trig_oe", reset_pin_oe, 1'b1);
    wr(8'h3c, 8'h02);
    skip(TRPF * TK - 20);
    chk1("trig_hold", reset_asserted, 1'b1);
    wait_on(1'b0, 1'b0, 60);
    chk1("trig_end", reset_asserted, 1'b0);
    skip(2);
    chk1("released_oe", reset_pin_oe, 1'b0);
    wr(8'h3b, 8'h0c);
    wr(8'h76, 8'h0a);
    skip(600);
    chk1("dog_kicked", dog_expiry_output_n, 1'b1);
    stop_kicks();
    // The first tick of a period may come after a single cycle, so allow one tick short
    skip((KTO - 1) * TK);
    chk1("dog_early", dog_expiry_output_n, 1'b1);
    wait_on(1'b1, 1'b0, 40);
    chk1("dog_late", dog_expiry_output_n, 1'b0);
    skip(300);
    chk1("dog_stays", dog_expiry_output_n, 1'b0);
    chk1("dog_no_rst", reset_asserted, 1'b0);
    @(posedge mclk) run <= 1'b1;
    wait_on(1'b1, 1'b1, 60);
    chk1("dog_kick", dog_expiry_output_n, 1'b1);
    @(posedge mclk) enable_pin <= 1'b0;
    @(posedge mclk) run <= 1'b0;
    skip(400);
    chk1("dog_disabled", dog_expiry_output_n, 1'b1);
    @(posedge mclk) enable_pin <= 1'b1;
    @(posedge mclk) run <= 1'b1;
    wr(8'h76, 8'h8a);
    skip(100);
    stop_kicks();
    wait_on(1'b1, 1'b0, 200);
    chk1("dog_trip", dog_expiry_output_n, 1'b0);
    wait_on(1'b1, 1'b1, 25);
    chk1("dog_pulse", dog_expiry_output_n, 1'b1);
    chk1("dog_rst", reset_asserted, 1'b1);
    @(posedge mclk) run <= 1'b1;
    rd(8'h20, 8'h02, 8'h02);
    wr(8'h20, 8'h02);
    rd(8'h20, 8'h02, 8'h00);
    wr(8'h76, 8'h00);
    @(posedge mclk) run <= 1'b0;
    skip(400);
    chk1("dog_off", dog_expiry_output_n, 1'b1);
    wr(8'h76, 8'h1a);
    skip(2000);
    chk1("dog_startup", dog_expiry_output_n, 1'b1);
    @(posedge mclk) run <= 1'b1;
    skip(200);
    stop_kicks();
    skip((KTO - 1) * TK);
    chk1("dog_normal", dog_expiry_output_n, 1'b1);
    wait_on(1'b1, 1'b0, 40);
    chk1("dog_normal_exp", dog_expiry_output_n, 1'b0);
    @(posedge mclk) power_on_done <= 1'b0;
    skip(6);
    chk1("no_power", reset_asserted, 1'b1);
    chk1("dog_cleared", dog_expiry_output_n, 1'b1);
    end_of_test();
  end
endmodule
`default_nettype wire
